/* File: design/external_memory_port_ctrl.sv */
// external memory port controller: address modes, programmable pin timing, register file
//
// Overview of operation
// (R1) pins are claimed only during an off-chip move, then released to port latches
// (R2) software parks the port latches high so idle pins rest inactive
// (R3) data pins are not driven while they act as inputs, e.g. during reads
// (R4) open-drain or push-pull choice stays with the port output mode registers
// (R5) mode 10: addresses below the on-chip size go on-chip, others off-chip
// (R6) bank mode 8-bit: page register decides and forms A15..8, all 16 lines driven
// (R7) bank mode 16-bit: data pointer decides; all 16 lines driven off-chip
// (R8) mode 11: every move goes off-chip, on-chip space hidden even at 0x0000
// (R9) off-only mode 8-bit: page ignored, A15..8 not driven, A7..0 from indirect
// (R10) off-only mode 16-bit: data pointer gives address, all 16 lines driven
// (R11) setup, hold, strobe and latch widths are programmable in core clocks
// (R12) access length is the sum of programmed times plus four cycles
// (R13) shortest non-multiplexed access is five cycles, one of them strobe
// (R14) multiplexed mode adds at least two latch cycles, seven minimum
// (R15) setup and hold fields reset to their maximum delay
// (R16) multiplexed or non-multiplexed operation is chosen in the config register
// (R17) the mode field selects one of four address mappings
// (R18) strobe starts after setup; address held through hold after strobe
// (R19) read data sampled at the end of the read strobe and returned; here the pins are taken two cycles before its end
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "ext_memory_interface_defs.svh"
module external_memory_port_ctrl
  import ext_memory_interface_pkg::*;
#(
  parameter logic [15:0] EXTERNAL_DATA_RAM_SPACE_SIZE = `EXT_MEMORY_INTERFACE_EXTERNAL_DATA_RAM_SPACE_SIZE
) (
  input  wire logic [`EXT_MEMORY_INTERFACE_REG_AW-1:0] reg_addr,     // register offset
  input  wire logic [7:0]              reg_wdata,    // register write data
  input  wire logic                    reg_wr,       // register write strobe
  input  wire logic                    reg_rd,       // register read strobe
  output logic      [7:0]              reg_rdata,    // read data, cycle after strobe
  input  wire logic                    clk,          // core clock, 40 MHz
  input  wire logic                    reset,        // async reset, active high
  input  wire logic                    ce,           // clock enable, freezes all state
  input  wire logic                    acc_req,      // move request pulse from core
  input  wire logic                    acc_write,    // 1 = write, 0 = read
  input  wire logic                    acc_wide,     // 1 = 16-bit pointer form
  input  wire logic [7:0]              acc_ind_addr, // indirect register low address
  input  wire logic [15:0]             acc_data_pointer_reg,     // data pointer register
  input  wire logic [7:0]              acc_wdata,    // byte to write
  output logic                         acc_done,     // completion pulse
  output logic      [7:0]              acc_rdata,    // byte read off-chip
  output logic                         acc_onchip,   // done pulse was an on-chip route
  output logic                         acc_busy,     // off-chip move in progress
  output logic      [15:0]             addr_drv,     // address pin levels
  output logic      [15:0]             addr_en,      // address pin drive enables
  output logic      [7:0]              data_drv,     // data pin levels
  output logic                         data_en,      // data pin drive enable
  input  wire logic [7:0]              data_pin,     // data pin levels seen
  output logic                         rd_strobe_n,  // read strobe, active low
  output logic                         wr_strobe_n,  // write strobe, active low
  output logic                         addr_latch,   // address latch pulse, active high
  output logic                         ctl_en,       // strobe/latch pin drive enable
  output logic                         port_claim    // pins taken from port latches
);

  ctrl_state_t r_r;
  ctrl_state_t r_nxt;
  logic [7:0]  din_s;

  // read data come from outside the clock domain
  pin_sync #(
    .W (8)
  ) u_din_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     (data_pin),
    .q     (din_s)
  );

  // programmed fields
  mem_mode_t  mode;
  logic [1:0] ale_f;
  logic [1:0] setup_f;
  logic [3:0] strb_f;
  logic [1:0] hold_f;
  logic [15:0] eff_addr;
  logic        off_sel;
  logic        phase_addr;
  logic        phase_data;

  assign mode    = mem_mode_t'(r_r.cfg[`EXT_MEMORY_INTERFACE_CFG_MODE_HI:`EXT_MEMORY_INTERFACE_CFG_MODE_LO]); // R17
  assign ale_f   = r_r.cfg[`EXT_MEMORY_INTERFACE_CFG_ALE_HI:`EXT_MEMORY_INTERFACE_CFG_ALE_LO]; // R11
  assign setup_f = r_r.tmg[`EXT_MEMORY_INTERFACE_TMG_SETUP_HI:`EXT_MEMORY_INTERFACE_TMG_SETUP_LO]; // R11
  assign strb_f  = r_r.tmg[`EXT_MEMORY_INTERFACE_TMG_STRB_HI:`EXT_MEMORY_INTERFACE_TMG_STRB_LO]; // R11
  assign hold_f  = r_r.tmg[`EXT_MEMORY_INTERFACE_TMG_HOLD_HI:`EXT_MEMORY_INTERFACE_TMG_HOLD_LO]; // R11

  // effective address: 8-bit form takes the page byte above the indirect byte
  assign eff_addr = acc_wide ? acc_data_pointer_reg : {r_r.page, acc_ind_addr}; // R6 R7 R10

  // route decision per memory mode
  always_comb begin
    case (mode)
      MODE_ONCHIP:       off_sel = 1'b0;
      MODE_SPLIT_NOBANK: off_sel = (eff_addr >= EXTERNAL_DATA_RAM_SPACE_SIZE);
      MODE_SPLIT_BANK:   off_sel = (eff_addr >= EXTERNAL_DATA_RAM_SPACE_SIZE); // R5 R6 R7
      MODE_OFFCHIP:      off_sel = 1'b1; // R8
      default:           off_sel = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    r_nxt      = r_r;
    r_nxt.done = 1'b0;
    phase_addr = 1'b0;
    phase_data = 1'b0;

    // register writes; only the defined config bits store
    if (reg_wr) begin
      case (reg_addr)
        `EXT_MEMORY_INTERFACE_OFS_CONFIG: r_nxt.cfg  = reg_wdata & `EXT_MEMORY_INTERFACE_CFG_WMASK; // R16 R17
        `EXT_MEMORY_INTERFACE_OFS_PAGE:   r_nxt.page = reg_wdata;
        `EXT_MEMORY_INTERFACE_OFS_TIMING: r_nxt.tmg  = reg_wdata; // R11
        default:          r_nxt.cfg  = r_r.cfg;
      endcase
    end

    // register reads; answer stands one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `EXT_MEMORY_INTERFACE_OFS_CONFIG: r_nxt.bus_rdata = r_r.cfg;
        `EXT_MEMORY_INTERFACE_OFS_PAGE:   r_nxt.bus_rdata = r_r.page;
        `EXT_MEMORY_INTERFACE_OFS_TIMING: r_nxt.bus_rdata = r_r.tmg;
        `EXT_MEMORY_INTERFACE_OFS_STATUS: begin
          r_nxt.bus_rdata = 8'h00;
          r_nxt.bus_rdata[`EXT_MEMORY_INTERFACE_STS_BUSY_BIT]   = r_r.busy;
          r_nxt.bus_rdata[`EXT_MEMORY_INTERFACE_STS_ONCHIP_BIT] = r_r.onchip;
          r_nxt.bus_rdata[`EXT_MEMORY_INTERFACE_STS_OFF_BIT]    = r_r.upper_drive;
        end
        default:          r_nxt.bus_rdata = 8'h00;
      endcase
    end

    // access sequencer; requests outside idle are ignored
    case (r_r.st)
      ST_IDLE: begin
        if (acc_req) begin
          if (off_sel) begin
            r_nxt.st          = ST_OVH_A; // R1 R12
            r_nxt.addr        = eff_addr;
            r_nxt.upper_drive = acc_wide || (mode == MODE_SPLIT_BANK); // R6 R9 R10
            r_nxt.mux         = r_r.cfg[`EXT_MEMORY_INTERFACE_CFG_MUX_BIT]; // R16
            r_nxt.write       = acc_write;
            r_nxt.wdata       = acc_wdata;
            r_nxt.onchip      = 1'b0;
            r_nxt.cnt         = `EXT_MEMORY_INTERFACE_CNT_ZERO;
          end else begin
            // on-chip route finishes without touching the pins
            r_nxt.done   = 1'b1;
            r_nxt.onchip = 1'b1;
          end
        end
      end
      ST_OVH_A: begin
        if (r_r.mux) begin
          r_nxt.st  = ST_ALE; // R14
          r_nxt.cnt = {2'h0, ale_f};
        end else begin
          phase_addr = 1'b1;
        end
      end
      ST_ALE: begin
        if (r_r.cnt == `EXT_MEMORY_INTERFACE_CNT_ZERO) begin
          r_nxt.st = ST_ALE_GAP; // R14
        end else begin
          r_nxt.cnt = r_r.cnt - `EXT_MEMORY_INTERFACE_CNT_ONE;
        end
      end
      ST_ALE_GAP: begin
        phase_addr = 1'b1;
      end
      ST_SETUP: begin
        if (r_r.cnt == `EXT_MEMORY_INTERFACE_CNT_ZERO) begin
          r_nxt.st  = ST_STROBE; // R18
          r_nxt.cnt = strb_f;
        end else begin
          r_nxt.cnt = r_r.cnt - `EXT_MEMORY_INTERFACE_CNT_ONE;
        end
      end
      ST_STROBE: begin
        if (r_r.cnt == `EXT_MEMORY_INTERFACE_CNT_ZERO) begin
          if (!r_r.write) begin
            r_nxt.rdata = din_s; // R19
          end
          phase_data = 1'b1;
        end else begin
          r_nxt.cnt = r_r.cnt - `EXT_MEMORY_INTERFACE_CNT_ONE;
        end
      end
      ST_HOLD: begin
        if (r_r.cnt == `EXT_MEMORY_INTERFACE_CNT_ZERO) begin
          r_nxt.st  = ST_OVH_B; // R18
          r_nxt.cnt = `EXT_MEMORY_INTERFACE_TAIL_CNT;
        end else begin
          r_nxt.cnt = r_r.cnt - `EXT_MEMORY_INTERFACE_CNT_ONE;
        end
      end
      ST_OVH_B: begin
        if (r_r.cnt == `EXT_MEMORY_INTERFACE_CNT_ZERO) begin
          r_nxt.st   = ST_IDLE; // R1 R12
          r_nxt.done = 1'b1;
        end else begin
          r_nxt.cnt = r_r.cnt - `EXT_MEMORY_INTERFACE_CNT_ONE;
        end
      end
      default: begin
        r_nxt.st = ST_IDLE;
      end
    endcase

    // a zero setup field goes straight to the strobe
    if (phase_addr) begin
      if (setup_f != 2'h0) begin
        r_nxt.st  = ST_SETUP; // R18
        r_nxt.cnt = {2'h0, setup_f} - `EXT_MEMORY_INTERFACE_CNT_ONE;
      end else begin
        r_nxt.st  = ST_STROBE; // R13
        r_nxt.cnt = strb_f;
      end
    end

    // a zero hold field goes straight to the tail overhead
    if (phase_data) begin
      if (hold_f != 2'h0) begin
        r_nxt.st  = ST_HOLD; // R18
        r_nxt.cnt = {2'h0, hold_f} - `EXT_MEMORY_INTERFACE_CNT_ONE;
      end else begin
        r_nxt.st  = ST_OVH_B; // R12
        r_nxt.cnt = `EXT_MEMORY_INTERFACE_TAIL_CNT;
      end
    end

    // pin levels registered from the next state so every pin leaves a flop
    r_nxt.busy     = (r_nxt.st != ST_IDLE);
    r_nxt.claim    = r_nxt.busy; // R1
    r_nxt.addr_drv = r_nxt.addr;
    r_nxt.addr_en  = 16'h0000;
    if (r_nxt.claim) begin
      r_nxt.addr_en[15:8] = r_nxt.upper_drive ? 8'hFF : 8'h00; // R6 R9
      r_nxt.addr_en[7:0]  = r_nxt.mux ? 8'h00 : 8'hFF; // R16
    end
    r_nxt.ale = (r_nxt.st == ST_ALE); // R14
    // only output mode is untouched here: drive enables alone reach the port
    r_nxt.rd_n = !((r_nxt.st == ST_STROBE) && !r_nxt.write); // R4 R18
    r_nxt.wr_n = !((r_nxt.st == ST_STROBE) && r_nxt.write); // R18
    if (r_nxt.mux && ((r_nxt.st == ST_ALE) || (r_nxt.st == ST_ALE_GAP))) begin
      r_nxt.data_drv = r_nxt.addr[7:0];
      r_nxt.data_en  = 1'b1;
    end else begin
      r_nxt.data_drv = r_nxt.wdata;
      // reads never drive the data lines while they are inputs
      r_nxt.data_en  = r_nxt.write && ((r_nxt.st == ST_SETUP) ||
                       (r_nxt.st == ST_STROBE) || (r_nxt.st == ST_HOLD)); // R3
    end
  end

  // state register; the reset value sets every delay to maximum
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_r      <= '0;
      r_r.st   <= ST_IDLE;
      r_r.cfg  <= `EXT_MEMORY_INTERFACE_CFG_RESET; // R15
      r_r.page <= `EXT_MEMORY_INTERFACE_PAGE_RESET;
      r_r.tmg  <= `EXT_MEMORY_INTERFACE_TMG_RESET; // R15
      r_r.rd_n <= 1'b1;
      r_r.wr_n <= 1'b1;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata   = r_r.bus_rdata;
  assign acc_done    = r_r.done;
  assign acc_rdata   = r_r.rdata;
  assign acc_onchip  = r_r.onchip;
  assign acc_busy    = r_r.busy;
  assign addr_drv    = r_r.addr_drv;
  assign addr_en     = r_r.addr_en;
  assign data_drv    = r_r.data_drv;
  assign data_en     = r_r.data_en;
  assign rd_strobe_n = r_r.rd_n;
  assign wr_strobe_n = r_r.wr_n;
  assign addr_latch  = r_r.ale;
  assign ctl_en      = r_r.claim;
  assign port_claim  = r_r.claim;

endmodule : external_memory_port_ctrl

/* File: design/ext_memory_interface_defs.svh */
// register offsets, field positions, reset values and timing counts of the memory port
`ifndef EXT_MEMORY_INTERFACE_DEFS_SVH
`define EXT_MEMORY_INTERFACE_DEFS_SVH

// register bus geometry
`define EXT_MEMORY_INTERFACE_REG_AW        2
`define EXT_MEMORY_INTERFACE_DW            8

// register offsets
`define EXT_MEMORY_INTERFACE_OFS_CONFIG    2'h0
`define EXT_MEMORY_INTERFACE_OFS_PAGE      2'h1
`define EXT_MEMORY_INTERFACE_OFS_TIMING    2'h2
`define EXT_MEMORY_INTERFACE_OFS_STATUS    2'h3

// extmem_config_reg fields
`define EXT_MEMORY_INTERFACE_CFG_ALE_HI    1
`define EXT_MEMORY_INTERFACE_CFG_ALE_LO    0
`define EXT_MEMORY_INTERFACE_CFG_MODE_HI   3
`define EXT_MEMORY_INTERFACE_CFG_MODE_LO   2
`define EXT_MEMORY_INTERFACE_CFG_MUX_BIT   4
`define EXT_MEMORY_INTERFACE_CFG_WMASK     8'h1F

// extmem_timing_reg fields
`define EXT_MEMORY_INTERFACE_TMG_SETUP_HI  7
`define EXT_MEMORY_INTERFACE_TMG_SETUP_LO  6
`define EXT_MEMORY_INTERFACE_TMG_STRB_HI   5
`define EXT_MEMORY_INTERFACE_TMG_STRB_LO   2
`define EXT_MEMORY_INTERFACE_TMG_HOLD_HI   1
`define EXT_MEMORY_INTERFACE_TMG_HOLD_LO   0

// reset values: every programmable delay at its maximum
`define EXT_MEMORY_INTERFACE_CFG_RESET     8'h03
`define EXT_MEMORY_INTERFACE_PAGE_RESET    8'h00
`define EXT_MEMORY_INTERFACE_TMG_RESET     8'hFF

// status register bits
`define EXT_MEMORY_INTERFACE_STS_BUSY_BIT  0
`define EXT_MEMORY_INTERFACE_STS_ONCHIP_BIT 1
`define EXT_MEMORY_INTERFACE_STS_OFF_BIT   2

// fixed overhead: one lead cycle plus a tail of this count plus one
`define EXT_MEMORY_INTERFACE_TAIL_CNT      4'h2
`define EXT_MEMORY_INTERFACE_CNT_ONE       4'h1
`define EXT_MEMORY_INTERFACE_CNT_ZERO      4'h0

// on-chip data space boundary, default
`define EXT_MEMORY_INTERFACE_EXTERNAL_DATA_RAM_SPACE_SIZE     16'h0200

`endif

/* File: design/ext_memory_interface_pkg.sv */
// types shared by the external memory port controller
package ext_memory_interface_pkg;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_OVH_A   = 8'h02,
    ST_ALE     = 8'h04,
    ST_ALE_GAP = 8'h08,
    ST_SETUP   = 8'h10,
    ST_STROBE  = 8'h20,
    ST_HOLD    = 8'h40,
    ST_OVH_B   = 8'h80
  } access_state_t;

  typedef enum logic [1:0] {
    MODE_ONCHIP       = 2'h0,
    MODE_SPLIT_NOBANK = 2'h1,
    MODE_SPLIT_BANK   = 2'h2,
    MODE_OFFCHIP      = 2'h3
  } mem_mode_t;

  typedef struct packed {
    access_state_t st;
    logic [3:0]    cnt;
    logic [15:0]   addr;
    logic          upper_drive;
    logic          mux;
    logic          write;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
    logic          done;
    logic          onchip;
    logic          busy;
    logic [7:0]    cfg;
    logic [7:0]    page;
    logic [7:0]    tmg;
    logic [7:0]    bus_rdata;
    logic [15:0]   addr_drv;
    logic [15:0]   addr_en;
    logic [7:0]    data_drv;
    logic          data_en;
    logic          rd_n;
    logic          wr_n;
    logic          ale;
    logic          claim;
  } ctrl_state_t;

endpackage : ext_memory_interface_pkg

/* File: design/pin_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,   // core clock
  input  wire logic         reset, // async reset, active high
  input  wire logic         ce,    // clock enable
  input  wire logic [W-1:0] d,     // asynchronous pin level
  output logic      [W-1:0] q      // synchronised level
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : pin_sync

/* File: verification/ext_memory_interface_port_assertions.sv */
// concurrent checks on the memory port pins and the access handshake
`timescale 1ns/100ps
module ext_memory_interface_port_assertions (
  input wire logic        clk,         // core clock
  input wire logic        reset,       // async reset, active high
  input wire logic        acc_done,    // completion pulse
  input wire logic        acc_onchip,  // last route was on-chip
  input wire logic        acc_busy,    // off-chip move running
  input wire logic [15:0] addr_drv,    // address pin levels
  input wire logic [15:0] addr_en,     // address pin enables
  input wire logic        data_en,     // data pin enable
  input wire logic        rd_strobe_n, // read strobe, active low
  input wire logic        wr_strobe_n, // write strobe, active low
  input wire logic        ctl_en,      // strobe pin enable
  input wire logic        port_claim   // pins taken from latches
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // the shortest off-chip move holds the pins five cycles
  sequence min_run_s;
    acc_busy [*5];
  endsequence

  claim_tracks_busy_a: assert property (port_claim == acc_busy && ctl_en == port_claim)
    else $error("pin claim differs from busy");
  released_pins_off_a: assert property (!port_claim |-> addr_en == 16'h0000 && !data_en)
    else $error("pins driven while released");
  read_no_drive_a: assert property (!rd_strobe_n |-> !data_en)
    else $error("data pins driven during read");
  min_length_a: assert property ($rose(acc_busy) |-> min_run_s)
    else $error("off-chip move shorter than five cycles");
  done_after_busy_a: assert property ($fell(acc_busy) |-> acc_done && !acc_onchip)
    else $error("no off-chip completion after busy");
  offchip_done_a: assert property (acc_done && !acc_onchip |-> $past(acc_busy))
    else $error("off-chip completion without busy");
  strobe_after_lead_a: assert property ($fell(rd_strobe_n) || $fell(wr_strobe_n)
    |-> $past(port_claim))
    else $error("strobe in first claimed cycle");
  addr_hold_a: assert property ($rose(rd_strobe_n) || $rose(wr_strobe_n)
    |-> port_claim && $stable(addr_drv))
    else $error("address not held after strobe");
  release_at_done_a: assert property (acc_done |-> !port_claim)
    else $error("pins still claimed at completion");
endmodule : ext_memory_interface_port_assertions

bind external_memory_port_ctrl ext_memory_interface_port_assertions u_ext_memory_interface_port_assertions (
  .clk, .reset, .acc_done, .acc_onchip, .acc_busy, .addr_drv, .addr_en, .data_en,
  .rd_strobe_n, .wr_strobe_n, .ctl_en, .port_claim
);

/* File: verification/ext_sram_model.sv */
// behavioural external byte memory on the parallel port pins
`timescale 1ns/100ps
module ext_sram_model (
  input  wire logic        clk,  // core clock
  input  wire logic [15:0] addr, // address wire levels
  input  wire logic [7:0]  din,  // data wire levels
  input  wire logic        rd_n, // read strobe, active low
  input  wire logic        wr_n, // write strobe, active low
  output logic      [7:0]  dout  // byte offered on the data wire
);
  logic [7:0] mem [0:255];
  logic [7:0] pat = 8'h5A;

  // upper lines folded in so their level matters to the stored place
  function automatic logic [7:0] fold_addr(input logic [15:0] a);
    return a[15:8] ^ a[7:0];
  endfunction : fold_addr

  // byte taken while write strobe is low; the pattern toggles every cycle
  always @(posedge clk) begin
    pat <= ~pat;
    if (!wr_n) begin
      mem[fold_addr(addr)] <= din;
    end
  end

  // outputs float outside reads, so a changing pattern stands in for them
  assign dout = !rd_n ? mem[fold_addr(addr)] : pat;
endmodule : ext_sram_model

/* File: verification/external_memory_port_ctrl_bench.sv */
// self-checking bench for the external memory port controller
`timescale 1ns/100ps
`include "ext_memory_interface_defs.svh"
module external_memory_port_ctrl_bench;
  logic        clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ce = 1'b1;
  logic        acc_req = 1'b0, acc_write = 1'b0, acc_wide = 1'b0;
  logic        acc_done, acc_onchip, acc_busy, data_en, rd_n, wr_n, ale, ctl_en, claim, got_on;
  logic [1:0]  reg_addr = 2'h0;
  logic [7:0]  reg_wdata = 8'h00, acc_ind = 8'h00, acc_wdata = 8'h00, reg_rdata, acc_rdata;
  logic [7:0]  data_drv, data_pin, mem_out, got_rd, v;
  logic [15:0] acc_data_pointer_reg = 16'h0000, addr_drv, addr_en, addr_wire, seen_addr, seen_en;
  int          miscompares = 0, checks_done = 0, busy_n, strb_n;

  always #12.5 clk = ~clk;

  // undriven address lines rest at the parked port latch level
  assign addr_wire = (addr_drv & addr_en) | ~addr_en;
  assign data_pin  = data_en ? data_drv : mem_out;

  external_memory_port_ctrl u_external_memory_port_ctrl (
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clk, .reset, .ce, .acc_req,
    .acc_write, .acc_wide, .acc_ind_addr(acc_ind), .acc_data_pointer_reg, .acc_wdata, .acc_done,
    .acc_rdata, .acc_onchip, .acc_busy, .addr_drv, .addr_en, .data_drv, .data_en, .data_pin,
    .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .addr_latch(ale), .ctl_en, .port_claim(claim));
  ext_sram_model u_ext_sram_model (.clk, .addr(addr_wire), .din(data_pin), .rd_n, .wr_n,
    .dout(mem_out));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_put(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_put

  // read data stand from the cycle after the strobe until the next read strobe
  task automatic reg_get(input logic [1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_get

  // one move; counts busy and strobe cycles and notes the address at the strobe
  task automatic move(input logic w, input logic wd, input logic [7:0] ind,
                      input logic [15:0] dp, input logic [7:0] wdat);
    int i;
    @(posedge clk);
    acc_req   <= 1'b1;
    acc_write <= w;
    acc_wide  <= wd;
    acc_ind   <= ind;
    acc_data_pointer_reg  <= dp;
    acc_wdata <= wdat;
    @(posedge clk);
    acc_req   <= 1'b0;
    busy_n = 0;
    strb_n = 0;
    for (i = 0; i < 200; i++) begin
      #1;
      if (acc_done === 1'b1) break;
      busy_n += int'(acc_busy === 1'b1);
      if (rd_n === 1'b0 || wr_n === 1'b0) begin
        strb_n++;
        seen_addr = addr_wire;
        seen_en = addr_en;
      end
      @(posedge clk);
    end
    if (i == 200) begin
      miscompares++;
      final_report();
    end
    got_on = acc_onchip;
    got_rd = acc_rdata;
  endtask : move

  task automatic t_reset();
    reg_get(`EXT_MEMORY_INTERFACE_OFS_CONFIG);
    chk("config reset", 16'(`EXT_MEMORY_INTERFACE_CFG_RESET), 16'(v));
    reg_get(`EXT_MEMORY_INTERFACE_OFS_PAGE);
    chk("page reset", 16'(`EXT_MEMORY_INTERFACE_PAGE_RESET), 16'(v));
    reg_get(`EXT_MEMORY_INTERFACE_OFS_TIMING);
    chk("timing reset", 16'(`EXT_MEMORY_INTERFACE_TMG_RESET), 16'(v));
    reg_put(`EXT_MEMORY_INTERFACE_OFS_CONFIG, 8'hFF);
    reg_get(`EXT_MEMORY_INTERFACE_OFS_CONFIG);
    chk("config bits", 16'h001F, 16'(v));
    reg_put(`EXT_MEMORY_INTERFACE_OFS_STATUS, 8'hFF);
    reg_get(`EXT_MEMORY_INTERFACE_OFS_STATUS);
    chk("status ro", 16'h0000, 16'(v));
    $display("test reset done");
  endtask : t_reset

  // access length is four plus setup, strobe, hold and latch widths
  task automatic t_timing();
    logic [7:0] cfg_t [4] = '{8'h0C, 8'h0C, 8'h1C, 8'h1D};
    logic [7:0] tmg_t [4] = '{8'h00, 8'h8D, 8'h00, 8'h43};
    int         len_t [4] = '{5, 11, 7, 12};
    int         stb_t [4] = '{1, 4, 1, 1};
    for (int k = 0; k < 4; k++) begin
      reg_put(`EXT_MEMORY_INTERFACE_OFS_CONFIG, cfg_t[k]);
      reg_put(`EXT_MEMORY_INTERFACE_OFS_TIMING, tmg_t[k]);
      move(1'b1, 1'b1, 8'h00, 16'h1230 + 16'(k), 8'hA0);
      chk("busy cycles", 16'(len_t[k]), 16'(busy_n));
      chk("strobe cycles", 16'(stb_t[k]), 16'(strb_n));
      chk("addr enables", cfg_t[k][4] ? 16'hFF00 : 16'hFFFF, seen_en);
    end
    $display("test timing done");
  endtask : t_timing

  task automatic route(input logic [7:0] cfg, input logic [7:0] pg, input logic wd,
                       input logic [7:0] ind, input logic [15:0] dp, input logic on,
                       input logic [15:0] ea, input logic [15:0] een);
    reg_put(`EXT_MEMORY_INTERFACE_OFS_CONFIG, cfg);
    reg_put(`EXT_MEMORY_INTERFACE_OFS_PAGE, pg);
    move(1'b1, wd, ind, dp, 8'h11);
    chk("onchip", 16'(on), 16'(got_on));
    chk("busy", on ? 16'h0000 : 16'h0005, 16'(busy_n));
    if (!on) begin
      chk("address", ea, seen_addr);
      chk("enables", een, seen_en);
    end
  endtask : route

  task automatic t_modes();
    reg_put(`EXT_MEMORY_INTERFACE_OFS_TIMING, 8'h00);
    route(8'h0C, 8'h05, 1'b0, 8'h34, 16'h0000, 1'b0, 16'hFF34, 16'h00FF);
    route(8'h0C, 8'h00, 1'b1, 8'h00, 16'h0000, 1'b0, 16'h0000, 16'hFFFF);
    route(8'h08, 8'h01, 1'b0, 8'h66, 16'hFFFF, 1'b1, 16'h0000, 16'h0000);
    route(8'h08, 8'h05, 1'b0, 8'h66, 16'h0000, 1'b0, 16'h0566, 16'hFFFF);
    route(8'h08, 8'h00, 1'b1, 8'h00, 16'h01FF, 1'b1, 16'h0000, 16'h0000);
    route(8'h08, 8'h00, 1'b1, 8'h00, 16'h0200, 1'b0, 16'h0200, 16'hFFFF);
    route(8'h00, 8'h05, 1'b1, 8'h00, 16'hF000, 1'b1, 16'h0000, 16'h0000);
    route(8'h04, 8'h05, 1'b0, 8'h34, 16'h0000, 1'b0, 16'hFF34, 16'h00FF);
    $display("test modes done");
  endtask : t_modes

  // long strobe so the synchronised sample falls inside it
  task automatic t_read();
    reg_put(`EXT_MEMORY_INTERFACE_OFS_CONFIG, 8'h0C);
    reg_put(`EXT_MEMORY_INTERFACE_OFS_TIMING, 8'h14);
    move(1'b1, 1'b1, 8'h00, 16'h0ABC, 8'hC3);
    move(1'b1, 1'b1, 8'h00, 16'h0ABD, 8'h3C);
    move(1'b0, 1'b1, 8'h00, 16'h0ABC, 8'h00);
    chk("read byte", 16'h00C3, 16'(got_rd));
    move(1'b0, 1'b1, 8'h00, 16'h0ABD, 8'h00);
    chk("read byte", 16'h003C, 16'(got_rd));
    $display("test read done");
  endtask : t_read

  // a frozen clock enable must keep a write out; a mid-run reset restores maximum delays
  task automatic t_ce_reset();
    reg_put(`EXT_MEMORY_INTERFACE_OFS_TIMING, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    reg_put(`EXT_MEMORY_INTERFACE_OFS_TIMING, 8'h55);
    ce <= 1'b1;
    reg_get(`EXT_MEMORY_INTERFACE_OFS_TIMING);
    chk("timing frozen", 16'h0000, 16'(v));
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    reg_get(`EXT_MEMORY_INTERFACE_OFS_TIMING);
    chk("timing re-reset", 16'(`EXT_MEMORY_INTERFACE_TMG_RESET), 16'(v));
    $display("test ce reset done");
  endtask : t_ce_reset

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_timing();
    t_modes();
    t_read();
    t_ce_reset();
    final_report();
  end
endmodule : external_memory_port_ctrl_bench
